// File: hdl/isvm_source_map.v
// Interrupt source to vector map with priority selection and status snapshot
`timescale 1ns/1ns
`include "isvm_regs.vh"
module isvm_source_map #(
  parameter [44:0] PRESENT_MASK = 45'h1FFFFFFFFFFF
) (
  // Clock and reset
  input  wire        clock,
  input  wire        rst,
  // Peripheral source events, index is request number
  input  wire [44:0] srcEvents,
  // Register port
  input  wire [7:0]  regAddr,
  input  wire [31:0] regWrData,
  input  wire        regWrStb,
  input  wire        regRdStb,
  output reg  [31:0] regRdData_ff,
  // Core side
  output reg         coreIrqValid_ff,
  output reg  [5:0]  coreVector_ff,
  output reg  [2:0]  corePriority_ff,
  output reg  [1:0]  coreSubPriority_ff,
  output reg         singleVectorMode_ff
);

  // ************************************************************
  // Request to vector table
  // ************************************************************
  function [5:0] vecOf;
    input integer req;
    begin
      case (req)
        // Core timer and software sources
        0:       vecOf = 6'h00;
        1:       vecOf = 6'h01;
        2:       vecOf = 6'h02;
        // Pins, timers, capture and compare units
        3:       vecOf = 6'h03;
        4:       vecOf = 6'h04;
        5:       vecOf = 6'h05;
        6:       vecOf = 6'h05;
        7:       vecOf = 6'h06;
        8:       vecOf = 6'h07;
        9:       vecOf = 6'h08;
        10:      vecOf = 6'h09;
        11:      vecOf = 6'h09;
        12:      vecOf = 6'h0A;
        13:      vecOf = 6'h0B;
        14:      vecOf = 6'h0C;
        15:      vecOf = 6'h0D;
        16:      vecOf = 6'h0D;
        17:      vecOf = 6'h0E;
        18:      vecOf = 6'h0F;
        19:      vecOf = 6'h10;
        20:      vecOf = 6'h11;
        21:      vecOf = 6'h11;
        22:      vecOf = 6'h12;
        23:      vecOf = 6'h13;
        24:      vecOf = 6'h14;
        25:      vecOf = 6'h15;
        26:      vecOf = 6'h15;
        27:      vecOf = 6'h16;
        // Analog, clock, flash, comparator and USB sources
        28:      vecOf = 6'h17;
        29:      vecOf = 6'h18;
        30:      vecOf = 6'h19;
        31:      vecOf = 6'h1A;
        32:      vecOf = 6'h1B;
        33:      vecOf = 6'h1C;
        34:      vecOf = 6'h1D;
        // Shared serial, UART and two-wire vectors
        35:      vecOf = 6'h1E;
        36:      vecOf = 6'h1E;
        37:      vecOf = 6'h1E;
        38:      vecOf = 6'h1F;
        39:      vecOf = 6'h1F;
        40:      vecOf = 6'h1F;
        41:      vecOf = 6'h20;
        42:      vecOf = 6'h20;
        43:      vecOf = 6'h20;
        // Port change
        44:      vecOf = 6'h21;
        default: vecOf = 6'h00;
      endcase
    end
  endfunction

  // Persistent sources: capture, ADC, USB, serial, UART, two-wire, port change
  function isPersistent;
    input integer req;
    begin
      case (req)
        // Core timer and software sources
        0:       isPersistent = 1'b0;
        1:       isPersistent = 1'b0;
        2:       isPersistent = 1'b0;
        // Pins, timers, capture and compare units
        3:       isPersistent = 1'b0;
        4:       isPersistent = 1'b0;
        5:       isPersistent = 1'b1;
        6:       isPersistent = 1'b1;
        7:       isPersistent = 1'b0;
        8:       isPersistent = 1'b0;
        9:       isPersistent = 1'b0;
        10:      isPersistent = 1'b1;
        11:      isPersistent = 1'b1;
        12:      isPersistent = 1'b0;
        13:      isPersistent = 1'b0;
        14:      isPersistent = 1'b0;
        15:      isPersistent = 1'b1;
        16:      isPersistent = 1'b1;
        17:      isPersistent = 1'b0;
        18:      isPersistent = 1'b0;
        19:      isPersistent = 1'b0;
        20:      isPersistent = 1'b1;
        21:      isPersistent = 1'b1;
        22:      isPersistent = 1'b0;
        23:      isPersistent = 1'b0;
        24:      isPersistent = 1'b0;
        25:      isPersistent = 1'b1;
        26:      isPersistent = 1'b1;
        27:      isPersistent = 1'b0;
        // Analog, clock, flash, comparator and USB sources
        28:      isPersistent = 1'b1;
        29:      isPersistent = 1'b0;
        30:      isPersistent = 1'b0;
        31:      isPersistent = 1'b0;
        32:      isPersistent = 1'b0;
        33:      isPersistent = 1'b0;
        34:      isPersistent = 1'b1;
        // Serial, UART and two-wire sources
        35:      isPersistent = 1'b1;
        36:      isPersistent = 1'b1;
        37:      isPersistent = 1'b1;
        38:      isPersistent = 1'b1;
        39:      isPersistent = 1'b1;
        40:      isPersistent = 1'b1;
        41:      isPersistent = 1'b1;
        42:      isPersistent = 1'b1;
        43:      isPersistent = 1'b1;
        // Port change
        44:      isPersistent = 1'b1;
        default: isPersistent = 1'b0;
      endcase
    end
  endfunction

  // ************************************************************
  // Address decode
  // ************************************************************
  wire       wrFlag0;
  wire       wrFlag1;
  wire       wrEn0;
  wire       wrEn1;
  wire       prioHit;
  wire [7:0] prioRel;
  wire [3:0] prioIdx;

  assign wrFlag0 = regWrStb && (regAddr == `ISVM_OFS_FLAG0);
  assign wrFlag1 = regWrStb && (regAddr == `ISVM_OFS_FLAG1);
  assign wrEn0   = regWrStb && (regAddr == `ISVM_OFS_ENABLE0);
  assign wrEn1   = regWrStb && (regAddr == `ISVM_OFS_ENABLE1);
  assign prioRel = regAddr - `ISVM_OFS_PRIO_BASE;
  assign prioIdx = prioRel[5:2];
  assign prioHit = (regAddr >= `ISVM_OFS_PRIO_BASE) && (prioRel[1:0] == 2'b00) &&
                   (prioRel[7:2] < 6'd9);

  // ************************************************************
  // Request cells
  // ************************************************************
  wire [44:0] flags;
  wire [44:0] enables;

  genvar g;
  generate
    for (g = 0; g < 45; g = g + 1)
    begin : gReq
      // Word g/32, bit g%32 for both flag and enable
      isvm_req_cell #(
        .PRESENT    (PRESENT_MASK[g]),
        .PERSISTENT (isPersistent(g))
      ) uCell (
        .clock     (clock),
        .rst       (rst),
        .srcEvent  (srcEvents[g]),
        .flagWrEn  ((g < 32) ? wrFlag0 : wrFlag1),
        .flagWrVal (regWrData[g % 32]),
        .enWrEn    ((g < 32) ? wrEn0 : wrEn1),
        .enWrVal   (regWrData[g % 32]),
        .flag_ff   (flags[g]),
        .enable_ff (enables[g])
      );
    end
  endgenerate

  // ************************************************************
  // Priority words
  // ************************************************************
  reg [31:0] prioWord_ff [0:8];
  integer    w;

  always @(posedge clock)
  begin
    if (rst)
    begin
      for (w = 0; w < 9; w = w + 1)
        prioWord_ff[w] <= 32'h00000000;
    end
    else if (regWrStb && prioHit)
      // Only priority and subpriority bits of each lane are kept
      prioWord_ff[prioIdx] <= regWrData & 32'h1F1F1F1F;
  end

  // ************************************************************
  // Selection
  // ************************************************************
  reg        selValid;
  reg [5:0]  selVec;
  reg [2:0]  selPrio;
  reg [1:0]  selSub;
  reg [5:0]  rv;
  reg [31:0] pw;
  reg [2:0]  rp;
  reg [1:0]  rs;
  integer    r;

  always @*
  begin
    selValid = 1'b0;
    selVec   = 6'h00;
    selPrio  = 3'h0;
    selSub   = 2'h0;
    rv       = 6'h00;
    pw       = 32'h00000000;
    rp       = 3'h0;
    rs       = 2'h0;
    for (r = 0; r < 45; r = r + 1)
    begin
      rv = vecOf(r);
      pw = prioWord_ff[rv[5:2]];
      rp = pw[{rv[1:0], 3'b000} + 4 -: 3];
      rs = pw[{rv[1:0], 3'b000} + 1 -: 2];
      // Strictly greater keeps the lowest request on a tie
      if (flags[r] && enables[r] && (rp != 3'h0) &&
          (!selValid || (rp > selPrio) || ((rp == selPrio) && (rs > selSub))))
      begin
        selValid = 1'b1;
        selVec   = rv;
        selPrio  = rp;
        selSub   = rs;
      end
    end
  end

  // ************************************************************
  // Core outputs and status snapshot
  // ************************************************************
  reg [2:0] statPrio_ff;
  reg [5:0] statVec_ff;
  wire      wrStatus;
  wire      wrMode;

  assign wrStatus = regWrStb && (regAddr == `ISVM_OFS_STATUS);
  assign wrMode   = regWrStb && (regAddr == `ISVM_OFS_MODE);

  always @(posedge clock)
  begin
    if (rst)
    begin
      coreIrqValid_ff     <= 1'b0;
      coreVector_ff       <= 6'h00;
      corePriority_ff     <= 3'h0;
      coreSubPriority_ff  <= 2'h0;
      statPrio_ff         <= 3'h0;
      statVec_ff          <= 6'h00;
      singleVectorMode_ff <= 1'b0;
    end
    else
    begin
      coreIrqValid_ff    <= selValid;
      coreVector_ff      <= selVec;
      corePriority_ff    <= selPrio;
      coreSubPriority_ff <= selSub;
      if (wrMode)
        singleVectorMode_ff <= regWrData[0];
      if (selValid)
      begin
        statPrio_ff <= selPrio;
        statVec_ff  <= selVec;
      end
      else if (wrStatus)
      begin
        statPrio_ff <= regWrData[`ISVM_STAT_PRIO_HI:`ISVM_STAT_PRIO_LO];
        statVec_ff  <= regWrData[`ISVM_STAT_VEC_HI:`ISVM_STAT_VEC_LO];
      end
    end
  end

  // ************************************************************
  // Read port
  // ************************************************************
  always @(posedge clock)
  begin
    if (rst)
      regRdData_ff <= 32'h00000000;
    else if (regRdStb)
    begin
      if (regAddr == `ISVM_OFS_FLAG0)
        regRdData_ff <= flags[31:0];
      else if (regAddr == `ISVM_OFS_FLAG1)
        regRdData_ff <= {19'h00000, flags[44:32]};
      else if (regAddr == `ISVM_OFS_ENABLE0)
        regRdData_ff <= enables[31:0];
      else if (regAddr == `ISVM_OFS_ENABLE1)
        regRdData_ff <= {19'h00000, enables[44:32]};
      else if (prioHit)
        regRdData_ff <= prioWord_ff[prioIdx];
      else if (regAddr == `ISVM_OFS_STATUS)
        regRdData_ff <= {21'h000000, statPrio_ff, 2'b00, statVec_ff};
      else if (regAddr == `ISVM_OFS_MODE)
        regRdData_ff <= {31'h00000000, singleVectorMode_ff};
      else
        regRdData_ff <= 32'h00000000;
    end
    else
      regRdData_ff <= 32'h00000000;
  end

endmodule // isvm_source_map

// File: hdl/isvm_regs.vh
// Register offsets, field positions and reset values of the interrupt source map
`ifndef ISVM_REGS_VH
`define ISVM_REGS_VH

// ************************************************************
// Register offsets (byte addresses, word aligned)
// ************************************************************
`define ISVM_OFS_FLAG0     8'h00
`define ISVM_OFS_FLAG1     8'h04
`define ISVM_OFS_ENABLE0   8'h10
`define ISVM_OFS_ENABLE1   8'h14
`define ISVM_OFS_PRIO_BASE 8'h20
`define ISVM_OFS_STATUS    8'h50
`define ISVM_OFS_MODE      8'h54

// ************************************************************
// Sizes
// ************************************************************
`define ISVM_NUM_REQ       45
`define ISVM_NUM_VEC       34
`define ISVM_NUM_PRIO_WORD 9

// ************************************************************
// Status register fields
// ************************************************************
`define ISVM_STAT_PRIO_HI  10
`define ISVM_STAT_PRIO_LO  8
`define ISVM_STAT_VEC_HI   5
`define ISVM_STAT_VEC_LO   0
`define ISVM_STAT_RESET    32'h00000000

// ************************************************************
// Fixed request / vector numbers
// ************************************************************
`define ISVM_REQ_CORE_TIMER 0
`define ISVM_REQ_ADC_DONE   28
`define ISVM_REQ_CLK_MON    29
`define ISVM_REQ_PORT_A_CHG 44
`define ISVM_VEC_CAPTURE1   5
`define ISVM_VEC_SERIAL1    30
`define ISVM_VEC_UART1      31
`define ISVM_VEC_TWOWIRE1   32
`define ISVM_VEC_PORT_A_CHG 33

`endif

// File: hdl/isvm_req_cell.v
// One request slot: pending flag with set-over-clear and its enable bit
`timescale 1ns/1ns
module isvm_req_cell #(
  parameter PRESENT    = 1,
  parameter PERSISTENT = 0
) (
  // Clock and reset
  input  wire clock,
  input  wire rst,
  // Source event
  input  wire srcEvent,
  // Software access
  input  wire flagWrEn,
  input  wire flagWrVal,
  input  wire enWrEn,
  input  wire enWrVal,
  // State
  output reg  flag_ff,
  output reg  enable_ff
);

  wire srcLive;
  reg  nxt_flag;

  // Absent sources never raise a flag
  assign srcLive = (PRESENT != 0) && srcEvent;

  always @*
  begin
    nxt_flag = flag_ff;
    if (flagWrEn)
      nxt_flag = flagWrVal;
    // Every present source re-asserts while the event level holds, persistent or not; set wins
    if (srcLive)
      nxt_flag = 1'b1;
  end

  always @(posedge clock)
  begin
    if (rst)
    begin
      flag_ff   <= 1'b0;
      enable_ff <= 1'b0;
    end
    else
    begin
      flag_ff <= (PRESENT != 0) ? nxt_flag : 1'b0;
      if (enWrEn)
        enable_ff <= enWrVal;
    end
  end

endmodule // isvm_req_cell

// File: tb/isvm_source_map_chk.sv
// Port assertions of the interrupt source map
`timescale 1ns/1ns
`include "isvm_regs.vh"
module isvm_source_map_chk #(
  parameter [44:0] PRESENT_MASK = 45'h1FFFFFFFFFFF
) (
  // Clock and reset
  input wire        clock,
  input wire        rst,
  // Inputs
  input wire [44:0] srcEvents,
  input wire [7:0]  regAddr,
  input wire [31:0] regWrData,
  input wire        regWrStb,
  input wire        regRdStb,
  // Outputs
  input wire [31:0] regRdData_ff,
  input wire        coreIrqValid_ff,
  input wire [5:0]  coreVector_ff,
  input wire [2:0]  corePriority_ff,
  input wire [1:0]  coreSubPriority_ff,
  input wire        singleVectorMode_ff
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence sRdStatus;
    regRdStb && regAddr == `ISVM_OFS_STATUS;
  endsequence
  sequence sCoreSteady;
    coreIrqValid_ff && $past(coreIrqValid_ff) && $stable(coreVector_ff)
      && $stable(corePriority_ff);
  endsequence
  chk_rd_idle: assert property (
    !$past(regRdStb) |-> regRdData_ff == 32'h00000000)
    else $error("read data not zero outside a read");
  chk_stat_pad: assert property (
    sRdStatus |=> (regRdData_ff & 32'hFFFFF8C0) == 32'h00000000)
    else $error("status unused bits not zero");
  chk_flag_pad: assert property (
    regRdStb && regAddr == `ISVM_OFS_FLAG1 |=> regRdData_ff[31:13] == 19'h00000)
    else $error("flag word one has bits above request 44");
  chk_en_pad: assert property (
    regRdStb && regAddr == `ISVM_OFS_ENABLE1 |=> regRdData_ff[31:13] == 19'h00000)
    else $error("enable word one has bits above request 44");
  chk_prio_lane: assert property (
    regRdStb && regAddr >= `ISVM_OFS_PRIO_BASE && regAddr < 8'h44
      |=> (regRdData_ff & 32'hE0E0E0E0) == 32'h00000000)
    else $error("priority word has bits outside the lanes");
  chk_absent_flag: assert property (
    regRdStb && regAddr == `ISVM_OFS_FLAG0
      |=> (regRdData_ff & ~PRESENT_MASK[31:0]) == 32'h00000000)
    else $error("absent source shows a flag");
  chk_prio_nonzero: assert property (
    coreIrqValid_ff |-> corePriority_ff != 3'h0)
    else $error("request presented at priority zero");
  chk_vec_range: assert property (
    coreIrqValid_ff |-> coreVector_ff <= 6'h21)
    else $error("presented vector beyond 33");
  chk_status_snap: assert property (
    sRdStatus ##0 sCoreSteady |=> regRdData_ff[5:0] == $past(coreVector_ff)
      && regRdData_ff[10:8] == $past(corePriority_ff))
    else $error("status differs from presented vector");
endmodule // isvm_source_map_chk

bind isvm_source_map isvm_source_map_chk #(.PRESENT_MASK(PRESENT_MASK)) u_chk (
  .clock(clock), .rst(rst), .srcEvents(srcEvents), .regAddr(regAddr),
  .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
  .regRdData_ff(regRdData_ff), .coreIrqValid_ff(coreIrqValid_ff),
  .coreVector_ff(coreVector_ff), .corePriority_ff(corePriority_ff),
  .coreSubPriority_ff(coreSubPriority_ff), .singleVectorMode_ff(singleVectorMode_ff));

// File: tb/isvm_core_model.sv
// Core side model that takes the presented vector only while single vector mode is set
`timescale 1ns/1ns
module isvm_core_model (
  // Clock and reset
  input  wire       clock,
  input  wire       rst,
  // Presented interrupt
  input  wire       irqValid,
  input  wire [5:0] vector,
  input  wire       singleMode,
  // Taken vector
  output reg  [5:0] seenVector_ff
);
  always @(posedge clock)
  begin
    if (rst)
      seenVector_ff <= 6'h00;
    else if (irqValid && singleMode)
      seenVector_ff <= vector;
  end
endmodule // isvm_core_model

// File: tb/isvm_source_map_bench.sv
// Self-checking bench of the interrupt source map
`timescale 1ns/1ns
`include "isvm_regs.vh"
module isvm_source_map_bench;
  reg         clock;
  reg         rst;
  reg  [44:0] srcEvents;
  reg  [7:0]  regAddr;
  reg  [31:0] regWrData;
  reg         regWrStb;
  reg         regRdStb;
  wire [31:0] regRdData_ff;
  wire        coreIrqValid_ff;
  wire [5:0]  coreVector_ff;
  wire [2:0]  corePriority_ff;
  wire [1:0]  coreSubPriority_ff;
  wire        singleVectorMode_ff;
  wire [5:0]  seenVector_ff;
  integer     n_fail;
  integer     checked;

  isvm_source_map #(.PRESENT_MASK(45'h1FFFBFFFFFFF)) dut (
    .clock(clock), .rst(rst), .srcEvents(srcEvents), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData_ff(regRdData_ff), .coreIrqValid_ff(coreIrqValid_ff),
    .coreVector_ff(coreVector_ff), .corePriority_ff(corePriority_ff),
    .coreSubPriority_ff(coreSubPriority_ff), .singleVectorMode_ff(singleVectorMode_ff));
  isvm_core_model core (.clock(clock), .rst(rst), .irqValid(coreIrqValid_ff),
    .vector(coreVector_ff), .singleMode(singleVectorMode_ff), .seenVector_ff(seenVector_ff));

  // ************************************************************
  // Bus and compare tasks
  // ************************************************************
  task chk(input [31:0] seen, input [31:0] exp, input string what);
    checked = checked + 1;
    if (seen !== exp)
    begin
      $display("BAD %s expected %h seen %h", what, exp, seen);
      n_fail = n_fail + 1;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    @(posedge clock) regAddr <= a; regWrData <= d; regWrStb <= 1'b1;
    @(posedge clock) regWrStb <= 1'b0;
  endtask
  task rd(input [7:0] a, input [31:0] exp, input string what);
    @(posedge clock) regAddr <= a; regRdStb <= 1'b1;
    @(posedge clock) regRdStb <= 1'b0;
    #1 chk(regRdData_ff, exp, what);
  endtask
  task ev(input [44:0] m);
    @(posedge clock) srcEvents <= m;
    @(posedge clock) srcEvents <= 45'h0;
    repeat (3) @(posedge clock);
    #1;
  endtask
  task clr;
    wr(`ISVM_OFS_FLAG0, 32'h00000000);
    wr(`ISVM_OFS_FLAG1, 32'h00000000);
    repeat (3) @(posedge clock);
  endtask
  task prep(input [31:0] p);
    reg [7:0] k;
    wr(`ISVM_OFS_ENABLE0, 32'hFFFFFFFF);
    wr(`ISVM_OFS_ENABLE1, 32'h00001FFF);
    for (k = 0; k < 9; k = k + 1)
      wr(`ISVM_OFS_PRIO_BASE + {k[5:0], 2'b00}, p);
    clr;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task t_reset;
    rd(`ISVM_OFS_STATUS, 32'h00000000, "status reset");
    rd(`ISVM_OFS_FLAG0, 32'h00000000, "flag reset");
    rd(8'hFC, 32'h00000000, "unmapped");
    wr(`ISVM_OFS_PRIO_BASE + 8'h04, 32'hFFFFFFFF);
    rd(`ISVM_OFS_PRIO_BASE + 8'h04, 32'h1F1F1F1F, "prio word");
    wr(`ISVM_OFS_ENABLE1, 32'hFFFFFFFF);
    rd(`ISVM_OFS_ENABLE1, 32'h00001FFF, "enable word");
    wr(`ISVM_OFS_MODE, 32'h00000001);
    rd(`ISVM_OFS_MODE, 32'h00000001, "mode word");
    chk({31'h0, singleVectorMode_ff}, 32'h00000001, "mode pin");
    wr(`ISVM_OFS_STATUS, 32'hFFFFFDE3);
    rd(`ISVM_OFS_STATUS, 32'h00000523, "status write");
    $display("test reset done");
  endtask
  task t_map;
    static int reqs[17] = '{0, 1, 2, 5, 6, 28, 29, 35, 36, 37, 38, 39, 40, 41, 42, 43, 44};
    static int vecs[17] = '{0, 1, 2, 5, 5, 23, 24, 30, 30, 30, 31, 31, 31, 32, 32, 32, 33};
    int i;
    prep(32'h05050505);
    for (i = 0; i < 17; i = i + 1)
    begin
      ev(45'h1 << reqs[i]);
      chk({31'h0, coreIrqValid_ff}, 1, "valid");
      chk({26'h0, coreVector_ff}, vecs[i], "vector");
      chk({26'h0, seenVector_ff}, vecs[i], "taken vector");
      rd(reqs[i] < 32 ? `ISVM_OFS_FLAG0 : `ISVM_OFS_FLAG1, 32'h1 << (reqs[i] % 32),
         "flag bit");
      rd(`ISVM_OFS_STATUS, 32'h00000100 | vecs[i], "status");
      clr;
    end
    $display("test map done");
  endtask
  task t_gate;
    prep(32'h00000000);
    ev(45'h8);
    chk({31'h0, coreIrqValid_ff}, 0, "zero prio");
    prep(32'h05050505);
    wr(`ISVM_OFS_ENABLE0, 32'h00000000);
    ev(45'h8);
    chk({31'h0, coreIrqValid_ff}, 0, "disabled");
    ev(45'h1 << 30);
    rd(`ISVM_OFS_FLAG0, 32'h00000008, "absent flag");
    $display("test gate done");
  endtask
  task t_pick;
    prep(32'h05050505);
    ev((45'h1 << 35) | (45'h1 << 38));
    chk({26'h0, coreVector_ff}, 30, "tie");
    wr(`ISVM_OFS_PRIO_BASE + 8'h1C, 32'h1D050505);
    repeat (3) @(posedge clock);
    #1 chk({26'h0, coreVector_ff}, 31, "prio win");
    chk({29'h0, corePriority_ff}, 7, "prio level");
    wr(`ISVM_OFS_PRIO_BASE + 8'h1C, 32'h06050505);
    repeat (3) @(posedge clock);
    #1 chk({26'h0, coreVector_ff}, 31, "sub win");
    chk({30'h0, coreSubPriority_ff}, 2, "sub level");
    clr;
    $display("test pick done");
  endtask

  // ************************************************************
  // Run control
  // ************************************************************
  task close_out;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    n_fail = n_fail + 1;
    close_out;
  end
  initial
  begin
    n_fail = 0;
    checked = 0;
    rst = 1'b1;
    srcEvents = 45'h0;
    regAddr = 8'h00;
    regWrData = 32'h00000000;
    regWrStb = 1'b0;
    regRdStb = 1'b0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    t_reset;
    t_map;
    t_gate;
    t_pick;
    close_out;
  end
endmodule // isvm_source_map_bench
